/* File: mcs_core.sv */
// instruction sequencer, data path and special registers of the 8-bit core
`timescale 1ns/1ps
`default_nettype none
module mcs_core (
  input wire logic clk,
  input wire logic rst_n,
  output logic [mcs_pkg::PC_W-1:0] prog_addr,
  input wire logic [mcs_pkg::IW_W-1:0] prog_word,
  input wire logic pwr_up,
  input wire logic wdt_timeout,
  output logic wdt_clear,
  output logic power_down,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [1:0] port_b_out,
  output logic [1:0] port_b_oe_n,
  output logic port_c_out,
  output logic [1:0] cycle_phase
);
  import mcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0] phase;
  logic [9:0] program_counter;
  logic [13:0] instr;
  logic instr_valid;
  logic lookup_busy;
  logic [9:0] lookup_addr;
  logic [5:0] lookup_dest;
  logic [9:0] return_slot;
  logic return_slot_index;
  logic [7:0] working_register;
  logic [5:0] indirect_pointer;
  logic [7:0] lookup_pointer;
  logic [5:0] lookup_high_byte;
  logic [3:0] arith_flags;
  logic watchdog_expiry_flag;
  logic sleep_entry_flag;
  logic [7:0] port_a_latch;
  logic [7:0] port_b_latch;
  logic port_c_latch;
  logic [7:0] port_a_meta;
  logic [7:0] port_a_sync;
  logic [7:0] port_b_meta;
  logic [7:0] port_b_sync;
  logic [7:0] ram_q;

  // decode and execute
  logic [3:0] op;
  logic [3:0] fn;
  logic [5:0] eff_addr;
  logic [5:0] wr_addr;
  logic [7:0] rd_val;
  logic exec;
  logic wr_en;
  logic [7:0] wr_val;
  logic acc_we;
  logic [7:0] next_acc;
  logic [3:0] flag_we;
  logic [3:0] next_flags;
  logic do_skip;
  logic do_jump;
  logic do_call;
  logic do_return;
  logic do_lookup;
  logic clear_op;
  logic halt_op;
  logic jump_low_wr;
  logic [10:0] sum;
  logic [7:0] logic_res;

  // {signed wrap, nibble carry, carry, 8-bit sum}
  function automatic logic [10:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] top;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
    top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
    alu_add = {mid[3] ^ top[1], lo[4], top[1], top[0], mid[2:0], lo[3:0]}; // RULE_20
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // instruction phases
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1; // RULE_01
    end
  end

  assign cycle_phase = phase;
  assign op = instr[13:10];
  assign fn = instr[9:6];
  assign exec = (phase == PH_LAST) && instr_valid && !lookup_busy;
  assign eff_addr = (instr[5:0] == ADDR_INDIRECT_WINDOW) ? indirect_pointer : instr[5:0]; // RULE_15
  assign wr_addr = lookup_busy ? lookup_dest : eff_addr;
  assign jump_low_wr = wr_en && (wr_addr == ADDR_JUMP_LOW);
  assign prog_addr = lookup_busy ? lookup_addr : program_counter;

  ////////////////////////////////////////////////////////////////////////////
  // data read mux
  always_comb begin
    if (eff_addr[GP_BIT]) begin
      rd_val = ram_q; // RULE_14
    end else if (eff_addr == ADDR_INDIRECT_POINTER) begin
      rd_val = {PTR_PAD, indirect_pointer}; // RULE_16
    end else if (eff_addr == ADDR_WORKING) begin
      rd_val = working_register; // RULE_17
    end else if (eff_addr == ADDR_JUMP_LOW) begin
      rd_val = program_counter[7:0]; // RULE_06
    end else if (eff_addr == ADDR_LOOKUP_POINTER) begin
      rd_val = lookup_pointer; // RULE_12
    end else if (eff_addr == ADDR_LOOKUP_HIGH) begin
      rd_val = {ZERO_PAD, lookup_high_byte}; // RULE_11
    end else if (eff_addr == ADDR_STATUS_FLAGS) begin
      rd_val = {ZERO_PAD, watchdog_expiry_flag, sleep_entry_flag, arith_flags}; // RULE_21
    end else if (eff_addr == ADDR_PORT_A) begin
      rd_val = port_a_sync;
    end else if (eff_addr == ADDR_PORT_B) begin
      rd_val = port_b_sync;
    end else if (eff_addr == ADDR_OUT_PORT_C) begin
      rd_val = {7'h00, port_c_latch};
    end else begin
      rd_val = 8'h00; // RULE_13 RULE_15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode and execute
  always_comb begin
    wr_en = 1'b0;
    wr_val = rd_val;
    acc_we = 1'b0;
    next_acc = working_register;
    flag_we = 4'h0;
    next_flags = arith_flags;
    do_skip = 1'b0;
    do_jump = 1'b0;
    do_call = 1'b0;
    do_return = 1'b0;
    do_lookup = 1'b0;
    clear_op = 1'b0;
    halt_op = 1'b0;
    sum = 11'h000;
    logic_res = 8'h00;
    if (lookup_busy && phase == PH_LAST) begin
      wr_en = 1'b1;
      wr_val = prog_word[7:0]; // RULE_11
    end else if (exec) begin
      case (op)
        OP_MISC: begin
          case (fn)
            FN_RETURN: begin
              do_return = 1'b1; // RULE_08
            end
            FN_WDT_CLEAR: begin
              clear_op = 1'b1;
            end
            FN_POWER_DOWN: begin
              halt_op = 1'b1;
            end
            FN_INC, FN_DEC, FN_INVERT, FN_CLEAR: begin
              if (fn == FN_INC) begin
                wr_val = rd_val + 8'h01;
              end else if (fn == FN_DEC) begin
                wr_val = rd_val - 8'h01;
              end else if (fn == FN_INVERT) begin
                wr_val = ~rd_val;
              end else begin
                wr_val = 8'h00;
              end
              wr_en = 1'b1;
              flag_we[FLG_ZERO] = 1'b1;
              next_flags[FLG_ZERO] = is_zero(wr_val); // RULE_20
            end
            FN_ROL_CARRY: begin
              wr_en = 1'b1;
              wr_val = {rd_val[6:0], arith_flags[FLG_CARRY]};
              flag_we[FLG_CARRY] = 1'b1;
              next_flags[FLG_CARRY] = rd_val[7]; // RULE_19
            end
            FN_ROR_CARRY: begin
              wr_en = 1'b1;
              wr_val = {arith_flags[FLG_CARRY], rd_val[7:1]};
              flag_we[FLG_CARRY] = 1'b1;
              next_flags[FLG_CARRY] = rd_val[0]; // RULE_19
            end
            FN_SKIP_NZ: begin
              do_skip = !is_zero(rd_val); // RULE_05
            end
            FN_SKIP_Z: begin
              do_skip = is_zero(rd_val); // RULE_05
            end
            FN_LOAD_W: begin
              acc_we = 1'b1;
              next_acc = rd_val; // RULE_17
            end
            FN_STORE_W: begin
              wr_en = 1'b1;
              wr_val = working_register; // RULE_17
            end
            default: begin
              wr_en = 1'b0;
            end
          endcase
        end
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_ADD_IMM: begin
          if (op == OP_ADD_IMM) begin
            sum = alu_add(working_register, instr[7:0], 1'b0);
          end else if (op == OP_ADD) begin
            sum = alu_add(working_register, rd_val, 1'b0);
          end else if (op == OP_ADDC) begin
            sum = alu_add(working_register, rd_val, arith_flags[FLG_CARRY]);
          end else if (op == OP_SUB) begin
            sum = alu_add(working_register, ~rd_val, 1'b1);
          end else begin
            sum = alu_add(working_register, ~rd_val, arith_flags[FLG_CARRY]);
          end
          acc_we = 1'b1;
          next_acc = sum[7:0];
          flag_we = 4'hf;
          next_flags[FLG_CARRY] = sum[8]; // RULE_19
          next_flags[FLG_NIBBLE] = sum[9]; // RULE_19
          next_flags[FLG_ZERO] = is_zero(sum[7:0]); // RULE_20
          next_flags[FLG_WRAP] = sum[10]; // RULE_20
        end
        OP_AND, OP_OR, OP_XOR: begin
          if (op == OP_AND) begin
            logic_res = working_register & rd_val;
          end else if (op == OP_OR) begin
            logic_res = working_register | rd_val;
          end else begin
            logic_res = working_register ^ rd_val;
          end
          acc_we = 1'b1;
          next_acc = logic_res;
          flag_we[FLG_ZERO] = 1'b1;
          next_flags[FLG_ZERO] = is_zero(logic_res); // RULE_20
        end
        OP_BSET: begin
          wr_en = 1'b1;
          wr_val = rd_val | (8'h01 << instr[8:6]); // RULE_14
        end
        OP_BCLR: begin
          wr_en = 1'b1;
          wr_val = rd_val & ~(8'h01 << instr[8:6]); // RULE_14
        end
        OP_LOOK_NOW, OP_LOOK_LAST: begin
          do_lookup = 1'b1; // RULE_12
        end
        OP_LOAD_IMM: begin
          acc_we = 1'b1;
          next_acc = instr[7:0]; // RULE_17
        end
        OP_JUMP: begin
          do_jump = 1'b1; // RULE_08
        end
        OP_CALL: begin
          do_jump = 1'b1;
          do_call = 1'b1; // RULE_08 RULE_22
        end
        default: begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and fetch pipeline
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_counter <= PC_RESET; // RULE_07
      instr <= IR_NOP;
      instr_valid <= 1'b0;
      lookup_busy <= 1'b0;
    end else if (phase == PH_LAST) begin
      if (lookup_busy) begin
        lookup_busy <= 1'b0; // RULE_12
      end else begin
        instr <= prog_word; // RULE_02
        instr_valid <= 1'b1;
        program_counter <= program_counter + 10'h001; // RULE_03 RULE_04
        if (do_return) begin
          program_counter <= return_slot; // RULE_08
          instr_valid <= 1'b0; // RULE_02
        end else if (do_jump) begin
          program_counter <= instr[9:0]; // RULE_08
          instr_valid <= 1'b0; // RULE_02
        end else if (jump_low_wr) begin
          program_counter <= {program_counter[9:8], wr_val}; // RULE_06
          instr_valid <= 1'b0; // RULE_02
        end else if (do_skip) begin
          instr_valid <= 1'b0; // RULE_05
        end else if (do_lookup) begin
          lookup_busy <= 1'b1; // RULE_12
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lookup_addr <= PC_RESET;
      lookup_dest <= ADDR_INDIRECT_WINDOW;
    end else if (do_lookup) begin
      lookup_dest <= eff_addr;
      if (op == OP_LOOK_LAST) begin
        lookup_addr <= {LAST_PAGE, lookup_pointer}; // RULE_10
      end else begin
        lookup_addr <= {program_counter[9:8], lookup_pointer}; // RULE_10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-entry return stack, hidden from software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      return_slot <= PC_RESET;
      return_slot_index <= 1'b0;
    end else if (do_call) begin
      return_slot <= program_counter; // RULE_09
      return_slot_index <= 1'b1;
    end else if (do_return) begin
      return_slot_index <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      working_register <= 8'h00;
    end else if (wr_en && wr_addr == ADDR_WORKING) begin
      working_register <= wr_val; // RULE_17
    end else if (acc_we) begin
      working_register <= next_acc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      indirect_pointer <= 6'h00;
    end else if (wr_en && wr_addr == ADDR_INDIRECT_POINTER) begin
      indirect_pointer <= wr_val[5:0]; // RULE_16
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lookup_pointer <= 8'h00;
      lookup_high_byte <= 6'h00;
    end else begin
      if (wr_en && wr_addr == ADDR_LOOKUP_POINTER) begin
        lookup_pointer <= wr_val; // RULE_12
      end
      if (lookup_busy && phase == PH_LAST) begin
        lookup_high_byte <= prog_word[13:8]; // RULE_11
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arith_flags <= 4'h0;
    end else if (wr_en && wr_addr == ADDR_STATUS_FLAGS) begin
      arith_flags <= wr_val[3:0]; // RULE_18
    end else begin
      arith_flags <= (arith_flags & ~flag_we) | (next_flags & flag_we);
    end
  end

  // watchdog flags ignore the chip reset; only their own events move them
  always_ff @(posedge clk) begin
    if (pwr_up) begin
      watchdog_expiry_flag <= 1'b0; // RULE_21
    end else if (wdt_timeout) begin
      watchdog_expiry_flag <= 1'b1; // RULE_18 RULE_21
    end else if (clear_op || halt_op) begin
      watchdog_expiry_flag <= 1'b0; // RULE_21
    end
  end

  always_ff @(posedge clk) begin
    if (pwr_up || clear_op) begin
      sleep_entry_flag <= 1'b0; // RULE_21
    end else if (halt_op) begin
      sleep_entry_flag <= 1'b1; // RULE_18 RULE_21
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdt_clear <= 1'b0;
      power_down <= 1'b0;
    end else begin
      wdt_clear <= clear_op;
      power_down <= halt_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ports A and B (B uses latch bits 1..0 only): a latch bit of zero pulls the pin low, one releases it; port C drives its latch bit onto the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_a_latch <= PORT_RESET;
      port_b_latch <= PORT_RESET;
      port_c_latch <= PORT_C_RESET;
    end else if (wr_en) begin
      if (wr_addr == ADDR_PORT_A) begin
        port_a_latch <= wr_val;
      end else if (wr_addr == ADDR_PORT_B) begin
        port_b_latch <= wr_val;
      end else if (wr_addr == ADDR_OUT_PORT_C) begin
        port_c_latch <= wr_val[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    port_a_meta <= port_a_in;
    port_a_sync <= port_a_meta;
    port_b_meta <= port_b_in;
    port_b_sync <= port_b_meta;
  end

  assign port_a_out = 8'h00;
  assign port_a_oe_n = port_a_latch;
  assign port_b_out = 2'h0;
  assign port_b_oe_n = port_b_latch[1:0];
  assign port_c_out = port_c_latch;

  ////////////////////////////////////////////////////////////////////////////
  // general purpose storage, 20h..3fh
  mcs_data_ram u_ram (
    .clk(clk),
    .rd_addr(eff_addr[RAM_AW-1:0]),
    .rd_data(ram_q),
    .wr_en(wr_en && wr_addr[GP_BIT]),
    .wr_addr(wr_addr[RAM_AW-1:0]),
    .wr_data(wr_val)
  );
endmodule // mcs_core
`default_nettype wire

/* File: mcs_core_sva.sv */
// port-level assertion checker for the core
`timescale 1ns/1ps
`default_nettype none
module mcs_core_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [mcs_pkg::PC_W-1:0] prog_addr,
  input wire logic wdt_clear,
  input wire logic power_down,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [1:0] port_b_oe_n,
  input wire logic port_c_out,
  input wire logic [1:0] cycle_phase
);
  import mcs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_first_fetch;
    (prog_addr == PC_RESET) [*4] ##1 prog_addr == 10'h001;
  endsequence
  sequence s_pulse_end(sig);
    cycle_phase == 2'h0 ##1 !sig;
  endsequence
  property p_phase_step;
    rst_n && $past(rst_n) |-> cycle_phase == 2'($past(cycle_phase) + 2'h1);
  endproperty
  property p_addr_hold;
    $past(rst_n) && $changed(prog_addr) |-> $past(cycle_phase) == PH_LAST;
  endproperty
  property p_addr_stable;
    $past(rst_n) && $changed(prog_addr) |=> $stable(prog_addr) [*3];
  endproperty
  property p_start;
    $rose(rst_n) |-> s_first_fetch;
  endproperty
  property p_clear_pulse;
    wdt_clear |-> s_pulse_end(wdt_clear);
  endproperty
  property p_down_pulse;
    power_down |-> s_pulse_end(power_down);
  endproperty
  property p_one_op;
    wdt_clear |-> !power_down;
  endproperty
  property p_latch_time;
    $past(rst_n) && ($changed(port_a_oe_n) || $changed(port_b_oe_n) || $changed(port_c_out))
      |-> cycle_phase == 2'h0;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not step");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved mid cycle");
  a_addr_stable: assert property (p_addr_stable) else $error("address not held");
  a_start: assert property (p_start) else $error("bad start after reset");
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse shape");
  a_down_pulse: assert property (p_down_pulse) else $error("power down pulse shape");
  a_one_op: assert property (p_one_op) else $error("two operations at once");
  a_latch_time: assert property (p_latch_time) else $error("port latch off phase");
endmodule // mcs_core_sva
bind mcs_core mcs_core_sva chk_i (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
  .wdt_clear(wdt_clear), .power_down(power_down), .port_a_oe_n(port_a_oe_n),
  .port_b_oe_n(port_b_oe_n), .port_c_out(port_c_out), .cycle_phase(cycle_phase));
`default_nettype wire

/* File: mcs_data_ram.sv */
// general purpose data storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module mcs_data_ram (
  input wire logic clk,
  input wire logic [mcs_pkg::RAM_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [mcs_pkg::RAM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  import mcs_pkg::*;
  logic [7:0] mem [RAM_WORDS];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // mcs_data_ram
`default_nettype wire

/* File: mcs_pkg.sv */
// constants shared by the core: data map, instruction encodings, flag positions
// Summary of operation
// RULE_01: one instruction cycle is four clock cycles, counted as four phases.
// RULE_02: fetch overlaps execution; anything that changes program flow costs two cycles.
// RULE_03: the program counter is ten bits wide and reaches 1024 program words.
// RULE_04: after each fetch the program counter advances by one word.
// RULE_05: a skip whose condition holds drops the fetched word and runs a dummy cycle.
// RULE_06: jump_low_byte at 06h is read/write; a write replaces counter bits 7..0 only.
// RULE_07: chip reset loads the program counter with zero.
// RULE_08: jump and call load all ten bits; call saves the return address, return restores it.
// RULE_09: the return stack holds one hidden entry; a new call overwrites it.
// RULE_10: lookup address is pointer low byte with current page or page three on top.
// RULE_11: lookup puts the low byte in data memory and the upper six bits in 08h.
// RULE_12: lookups take two cycles; 08h is read-only, lookup_pointer at 07h is read/write.
// RULE_13: special registers sit at their fixed addresses; other addresses below 20h read 00h.
// RULE_14: general storage is 20h to 3fh; every location supports single-bit set and clear.
// RULE_15: address 00h reaches the location named by indirect_pointer; pointing at 00h is void.
// RULE_16: indirect_pointer keeps six written bits and reads ones in bits 7..6.
// RULE_17: working_register is also location 05h, takes immediates, carries data moves.
// RULE_18: status writes change arithmetic flags only, never the two watchdog flags.
// RULE_19: carry bit 0 and nibble carry bit 1 track add carry or subtract no-borrow.
// RULE_20: zero bit 2 flags a zero result; bit 3 flags carry-in differing from carry-out.
// RULE_21: bits 4 and 5 follow power-up, watchdog clear, power-down and time-out; 7..6 read 0.
// RULE_22: a call saves no status; only the return address is kept.
package mcs_pkg;
  localparam int PC_W = 10;
  localparam int IW_W = 14;
  localparam int DA_W = 6;
  localparam int RAM_AW = 5;
  localparam int RAM_WORDS = 32;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [13:0] IR_NOP = 14'h0000;
  localparam logic [1:0] LAST_PAGE = 2'h3;
  localparam logic [1:0] PTR_PAD = 2'h3;
  localparam logic [1:0] ZERO_PAD = 2'h0;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic PORT_C_RESET = 1'b1;
  localparam logic [5:0] ADDR_INDIRECT_WINDOW = 6'h00;
  localparam logic [5:0] ADDR_INDIRECT_POINTER = 6'h01;
  localparam logic [5:0] ADDR_WORKING = 6'h05;
  localparam logic [5:0] ADDR_JUMP_LOW = 6'h06;
  localparam logic [5:0] ADDR_LOOKUP_POINTER = 6'h07;
  localparam logic [5:0] ADDR_LOOKUP_HIGH = 6'h08;
  localparam logic [5:0] ADDR_STATUS_FLAGS = 6'h0a;
  localparam logic [5:0] ADDR_PORT_A = 6'h12;
  localparam logic [5:0] ADDR_PORT_B = 6'h14;
  localparam logic [5:0] ADDR_OUT_PORT_C = 6'h16;
  localparam int GP_BIT = 5;
  localparam int FLG_CARRY = 0;
  localparam int FLG_NIBBLE = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_WRAP = 3;
  // major opcode, instruction bits 13..10
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h1;
  localparam logic [3:0] OP_ADDC = 4'h2;
  localparam logic [3:0] OP_SUB = 4'h3;
  localparam logic [3:0] OP_SUBC = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_OR = 4'h6;
  localparam logic [3:0] OP_XOR = 4'h7;
  localparam logic [3:0] OP_BSET = 4'h8;
  localparam logic [3:0] OP_BCLR = 4'h9;
  localparam logic [3:0] OP_LOOK_NOW = 4'ha;
  localparam logic [3:0] OP_LOOK_LAST = 4'hb;
  localparam logic [3:0] OP_LOAD_IMM = 4'hc;
  localparam logic [3:0] OP_ADD_IMM = 4'hd;
  localparam logic [3:0] OP_JUMP = 4'he;
  localparam logic [3:0] OP_CALL = 4'hf;
  // minor opcode of OP_MISC, instruction bits 9..6
  localparam logic [3:0] FN_NOP = 4'h0;
  localparam logic [3:0] FN_RETURN = 4'h1;
  localparam logic [3:0] FN_WDT_CLEAR = 4'h2;
  localparam logic [3:0] FN_POWER_DOWN = 4'h3;
  localparam logic [3:0] FN_INC = 4'h4;
  localparam logic [3:0] FN_DEC = 4'h5;
  localparam logic [3:0] FN_ROL_CARRY = 4'h6;
  localparam logic [3:0] FN_ROR_CARRY = 4'h7;
  localparam logic [3:0] FN_INVERT = 4'h8;
  localparam logic [3:0] FN_SKIP_NZ = 4'h9;
  localparam logic [3:0] FN_SKIP_Z = 4'ha;
  localparam logic [3:0] FN_LOAD_W = 4'hb;
  localparam logic [3:0] FN_STORE_W = 4'hc;
  localparam logic [3:0] FN_CLEAR = 4'hd;
endpackage

/* File: mcs_prog_mem.sv */
// program memory model that settles a few cycles after the address moves
`timescale 1ns/1ps
`default_nettype none
module mcs_prog_mem #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic [mcs_pkg::PC_W-1:0] prog_addr,
  output logic [mcs_pkg::IW_W-1:0] prog_word
);
  import mcs_pkg::*;
  logic [IW_W-1:0] mem [0:1023];
  logic [PC_W-1:0] last_addr = '1;
  logic [IW_W-1:0] stale = '0;
  int age = 0;
  // until settled, show the inverse of the previous answer
  assign prog_word = (age >= LAT && prog_addr == last_addr) ? mem[prog_addr] : ~stale;
  always_ff @(posedge clk) begin
    if (prog_addr != last_addr) begin
      last_addr <= prog_addr;
      age <= 0;
    end else if (age < LAT) begin
      age <= age + 1;
    end else begin
      stale <= mem[last_addr];
    end
  end
endmodule // mcs_prog_mem
`default_nettype wire

/* File: testbench.sv */
// self-checking bench running short programs on the core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcs_pkg::*;
  logic clk = 1'b0;
  logic rst_n, pwr_up, wdt_timeout, wdt_clear, power_down, port_c_out;
  logic [7:0] port_a_in, port_b_in, port_a_out, port_a_oe_n;
  logic [1:0] port_b_out, port_b_oe_n, cycle_phase;
  logic [PC_W-1:0] prog_addr, w, fin;
  logic [IW_W-1:0] prog_word;
  logic tmo = 1'b0;
  int num_errors;
  int checks;
  initial begin
    forever #2.5 clk = ~clk;
  end
  mcs_core dut (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_word(prog_word),
    .pwr_up(pwr_up), .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
    .power_down(power_down), .port_a_in(port_a_in), .port_a_out(port_a_out),
    .port_a_oe_n(port_a_oe_n), .port_b_in(port_b_in), .port_b_out(port_b_out),
    .port_b_oe_n(port_b_oe_n), .port_c_out(port_c_out), .cycle_phase(cycle_phase));
  mcs_prog_mem #(.LAT(2)) mem_i (.clk(clk), .prog_addr(prog_addr), .prog_word(prog_word));
  function automatic logic [13:0] mi(input logic [3:0] f, input logic [5:0] m);
    return {OP_MISC, f, m};
  endfunction
  task automatic put(input logic [13:0] x);
    mem_i.mem[w] = x;
    w = w + 10'h001;
  endtask
  task automatic ldi(input logic [7:0] v);
    put({OP_LOAD_IMM, 2'h0, v});
  endtask
  task automatic stw(input logic [5:0] m);
    put(mi(FN_STORE_W, m));
  endtask
  task automatic ldw(input logic [5:0] m);
    put(mi(FN_LOAD_W, m));
  endtask
  task automatic init;
    for (int i = 0; i < 1024; i++) mem_i.mem[i] = IR_NOP;
    w = '0;
  endtask
  task automatic spin;
    fin = w;
    put({OP_JUMP, w});
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset with power-up, run until the closing self-jump is fetched
  task automatic go(input string name);
    int n;
    @(posedge clk);
    #1 rst_n = 1'b0;
    pwr_up = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    pwr_up = 1'b0;
    wdt_timeout = tmo;
    n = 0;
    while (prog_addr !== fin && n < 2000) begin
      @(posedge clk);
      #1 wdt_timeout = 1'b0;
      n++;
    end
    if (n == 2000) begin
      num_errors++;
      $display("unexpected end of program %s: expected %h, seen %h", name, fin, prog_addr);
      results;
    end
    repeat (16) @(posedge clk);
    #1 $display("test %s finished", name);
  endtask
  initial begin
    rst_n = 1'b0;
    pwr_up = 1'b1;
    wdt_timeout = 1'b0;
    port_a_in = 8'h3c;
    port_b_in = 8'h96;
    num_errors = 0;
    checks = 0;
    w = '0;
    fin = '0;
    repeat (2) @(posedge clk);
    init; ldi(8'h5a); stw(6'h21); put({OP_BSET, 4'h0, 6'h21}); put({OP_BCLR, 4'h1, 6'h21});
    ldi(8'h21); stw(6'h01); ldw(6'h00); stw(6'h12); put(mi(FN_WDT_CLEAR, 6'h00)); spin;
    go("indirect");
    check("indirect read", port_a_oe_n, 8'h59);
    init; ldi(8'h80); stw(6'h01); ldw(6'h01); stw(6'h12); ldw(6'h12); stw(6'h16); spin;
    go("pointer");
    check("pointer readback", port_a_oe_n, 8'hc0);
    check("port a read", {7'h00, port_c_out}, {7'h00, port_a_in[0]});
    check("pin level", port_a_out | {6'h00, port_b_out}, 8'h00);
    init; ldi(8'h00); stw(6'h01); ldi(8'h77); stw(6'h00); ldw(6'h00); stw(6'h12);
    ldw(6'h03); stw(6'h14); ldw(6'h14); stw(6'h16); spin; go("reserved");
    check("self indirect", port_a_oe_n, 8'h00);
    check("reserved read", {6'h00, port_b_oe_n}, 8'h00);
    check("port b read", {7'h00, port_c_out}, {7'h00, port_b_in[0]});
    init; mem_i.mem[10'h340] = 14'h2a5e; mem_i.mem[10'h040] = 14'h0133;
    ldi(8'h40); stw(6'h07); put({OP_LOOK_NOW, 4'h0, 6'h22}); put({OP_LOOK_LAST, 4'h0, 6'h21});
    ldi(8'h01); stw(6'h08); ldw(6'h21); stw(6'h14); ldw(6'h08); stw(6'h12);
    ldw(6'h22); stw(6'h16); spin; go("lookup");
    check("lookup high", port_a_oe_n, 8'h2a);
    check("last page low", {6'h00, port_b_oe_n}, 8'h02);
    check("current page low", {7'h00, port_c_out}, 8'h01);
    init; put({OP_CALL, 10'h010}); stw(6'h12); spin; w = 10'h010; ldi(8'h3c);
    put(mi(FN_SKIP_NZ, 6'h05)); ldi(8'hff); put(mi(FN_SKIP_Z, 6'h05));
    put({OP_ADD_IMM, 10'h001}); put(mi(FN_RETURN, 6'h00)); go("call");
    check("call and skips", port_a_oe_n, 8'h3d);
    init; ldi(8'h08); stw(6'h06); ldi(8'h11); stw(6'h12); w = 10'h008; stw(6'h14); spin;
    go("short jump");
    check("skipped store", port_a_oe_n, 8'hff);
    check("jump target", {6'h00, port_b_oe_n}, 8'h00);
    // time-out pulse right after release sets the expiry flag
    tmo = 1'b1;
    init; ldi(8'h01); stw(6'h21); ldi(8'hff); put({OP_ADD, 4'h0, 6'h21});
    ldw(6'h0a); stw(6'h12); spin; go("flags");
    check("add flags", port_a_oe_n, 8'h27);
    init; put(mi(FN_POWER_DOWN, 6'h00)); ldi(8'hff); stw(6'h0a); ldw(6'h0a); stw(6'h12);
    spin; go("status write");
    check("status write", port_a_oe_n, 8'h1f);
    results;
  end
endmodule // testbench
`default_nettype wire
